//--- logic/timing_sched_consts.svh
// Purpose: named constants of the radio timing scheduler and its setting link
// Assumes: included by bare name from the device and host design files
// Notes: timing tables are packed, entry 0 in the low bits
`ifndef TIMING_SCHED_CONSTS_SVH
`define TIMING_SCHED_CONSTS_SVH
// frame bytes
`define START_BYTE 8'h02
`define CMD_WRITE_REQ 8'h11
`define CMD_READ_REQ 8'h10
`define CMD_WRITE_CNF 8'h51
`define CMD_READ_CNF 8'h50
`define STATUS_OK 8'h00
`define STATUS_FAIL 8'h01
`define WRITE_LEN 17'h00002
`define READ_LEN 17'h00001
`define HDR_BYTES 17'h00004
`define WRITE_FRAME_BYTES 3'h7
`define READ_FRAME_BYTES 3'h6
`define RSP_LEN_WRITE 8'h01
`define RSP_LEN_READ 8'h02
// setting indices, ranges and defaults
`define IDX_LINK 8'h08
`define IDX_DISC 8'h09
`define IDX_RATIO 8'h0a
`define LINK_MAX 8'h06
`define LINK_DEF 8'h01
`define DISC_MAX 8'h05
`define DISC_DEF 8'h01
`define RATIO_MIN 8'h01
`define RATIO_MAX 8'h0a
`define RATIO_DEF 8'h02
// timing: clock period and millisecond in ns, second in ms
`define CLK_PERIOD_NS 4
`define MS_NS 1000000
`define MS_PER_S 16'h03e8
`define NEG_FIRST_S 8'h05
`define NEG_RETRY_S 8'h0a
`define NEG_RETRIES 2'h3
// discovery profile tables (ms, ms, s)
`define ADV_MS_TAB {16'h2800, 16'h1388, 16'h03e8, 16'h00fa, 16'h0028, 16'h0014}
`define WIN_MS_TAB {16'h2800, 16'h186a, 16'h04e2, 16'h0138, 16'h0032, 16'h0019}
`define SETUP_S_TAB {8'h23, 8'h14, 8'h05, 8'h02, 8'h02, 8'h01}
// link profile tables (ms, ms, s)
`define MIN_MS_TAB {16'h0008, 16'h07d0, 16'h02ee, 16'h00c8, 16'h0032, 16'h0014, 16'h0008}
`define MAX_MS_TAB {16'h0008, 16'h0fa0, 16'h08ca, 16'h03e8, 16'h00fa, 16'h004b, 16'h001e}
`define SUP_S_TAB {8'h04, 8'h19, 8'h0f, 8'h08, 8'h04, 8'h04, 8'h04}
// host register offsets and fields
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_MASK 4'h8
`define REG_RESULT 4'hc
`define CTRL_GO 0
`define CTRL_WRITE 1
`define ST_DONE 0
`define ST_ERR 1
`endif

//--- logic/timing_sched_pkg.sv
// Purpose: shared types of the radio timing scheduler
// Assumes: nothing
// Notes: state codes left to the tool
package timing_sched_pkg;
	typedef enum logic [1:0] {IDLE_ADV, SCANNING, CENTRAL_LINK, PERIPHERAL_LINK} mode_type;
	typedef enum logic [2:0] {NEG_OFF, NEG_WAIT, NEG_ASK, NEG_AGREED, NEG_FAILED} neg_type;
endpackage

//--- logic/setting_link_if.sv
// Purpose: byte link between host controller and scheduler device
// Assumes: both ends on CLK; a valid byte is taken in its one cycle
// Notes: no back-pressure, each end always accepts
interface setting_link_if;
	logic h_valid; // host byte valid
	logic [7:0] h_data; // host byte
	logic d_valid; // device byte valid
	logic [7:0] d_data; // device byte
	modport device(input h_valid, input h_data, output d_valid, output d_data);
	modport host(input d_valid, input d_data, output h_valid, output h_data);
endinterface

//--- logic/timing_sched_device.sv
// Purpose: settings store, frame answering and radio timing scheduler
// Assumes: user-side inputs are synchronous to CLK
// Notes: one millisecond enable drives every timer
// Summary of operation
// - scan ratio setting index 10, 1-10, default 2
// - scan one window, suspend, switch channel
// - discovery profile index 9, 0-5, default 1
// - advertise once per profile period
// - scan only during profile window
// - channel switch per ratio-derived scan interval
// - connection setup answered within profile timeout
// - link profile index 8, 0-6, default 1
// - interval bounds from link profile table
// - silent link lost after supervision timeout
// - central applies own interval settings
// - mismatch: ask after 5 s, accept
// - three retries 10 s apart, then shutdown
// - peripheral accepts central's interval update
// - central accepts peripheral's parameter updates
// - write frame answered 0x51 status
// - read frame answered 0x50 status value
`include "timing_sched_consts.svh"
module timing_sched_device
	import timing_sched_pkg::*;
#(
	parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
	input wire logic CLK, // system clock
	input wire logic SYS_RST, // synchronous reset, high
	setting_link_if.device LINK, // command byte link
	input wire mode_type MODE, // radio activity state
	input wire logic CONN_PENDING, // connection request awaiting answer
	input wire logic LINK_ACTIVITY, // any communication on the link
	input wire logic INTV_MATCH, // peer intervals equal ours
	input wire logic PEER_ACCEPT, // central accepted our intervals
	input wire logic PEER_REJECT, // central rejected our intervals
	input wire logic PEER_UPDATE_REQ, // peer asks interval update
	output logic ADV_TX, // send advertising packet, pulse
	output logic SCAN_ON, // receiver scanning, level
	output logic CHAN_SWITCH, // switch scan channel, pulse
	output logic SETUP_TIMEOUT, // setup not answered in time
	output logic LINK_LOST, // supervision timeout hit
	output logic INTV_REQ, // ask central for our intervals, pulse
	output logic LINK_SHUTDOWN, // close connection
	output logic UPDATE_ACCEPT, // accept peer update, pulse
	output logic OWN_INTV, // our interval settings govern
	output logic [15:0] INTV_MIN, // minimum connection interval ms
	output logic [15:0] INTV_MAX // maximum connection interval ms
);
	localparam logic [95:0] ADV_TAB = `ADV_MS_TAB;
	localparam logic [95:0] WIN_TAB = `WIN_MS_TAB;
	localparam logic [47:0] SETUP_TAB = `SETUP_S_TAB;
	localparam logic [111:0] MIN_TAB = `MIN_MS_TAB;
	localparam logic [111:0] MAX_TAB = `MAX_MS_TAB;
	localparam logic [55:0] SUP_TAB = `SUP_S_TAB;

	logic [7:0] link_prof_r, disc_prof_r, ratio_r;
	logic [31:0] div_r;
	logic [16:0] ph_r;
	logic [15:0] setup_r, sup_r, nt_r;
	logic [1:0] tries_r;
	mode_type mode_prev_r;
	neg_type neg_r;
	logic [16:0] rx_pos_r, rx_len_r;
	logic [7:0] rx_cmd_r, rx_idx_r, rx_val_r, rx_xor_r;
	logic [7:0] tx_b_r [7];
	logic [7:0] rsp_b [7];
	logic [2:0] tx_n_r, tx_pos_r;

	// millisecond enable
	wire tick = div_r == 32'(MS_CYCLES - 1);
	always_ff @(posedge CLK) begin
		if (SYS_RST || tick) div_r <= '0;
		else div_r <= div_r + 32'h1;
	end

	// profile lookups
	wire [15:0] adv_ms = ADV_TAB[16*disc_prof_r[2:0] +: 16];
	wire [15:0] win_ms = WIN_TAB[16*disc_prof_r[2:0] +: 16];
	wire [16:0] scan_int = 17'(win_ms * ratio_r[3:0]);
	wire [15:0] setup_ms = 16'(SETUP_TAB[8*disc_prof_r[2:0] +: 8] * `MS_PER_S);
	wire [15:0] sup_ms = 16'(SUP_TAB[8*link_prof_r[2:0] +: 8] * `MS_PER_S);
	wire [15:0] first_ms = 16'(`NEG_FIRST_S * `MS_PER_S);
	wire [15:0] retry_ms = 16'(`NEG_RETRY_S * `MS_PER_S);
	wire mode_chg = MODE != mode_prev_r;
	wire conn = MODE == CENTRAL_LINK || MODE == PERIPHERAL_LINK;
	wire adv_wrap = MODE == IDLE_ADV && ph_r >= {1'b0, adv_ms} - 17'h1;
	wire scan_wrap = MODE == SCANNING && ph_r >= scan_int - 17'h1;

	// advertising and scan phase, restarted on any activity change
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			mode_prev_r <= IDLE_ADV;
			ph_r <= '0;
			ADV_TX <= 1'b0;
			CHAN_SWITCH <= 1'b0;
			SCAN_ON <= 1'b0;
		end else begin
			mode_prev_r <= MODE;
			if (mode_chg) ph_r <= '0;
			else if (tick) ph_r <= (adv_wrap || scan_wrap) ? '0 : ph_r + 17'h1;
			ADV_TX <= !mode_chg && tick && adv_wrap;
			CHAN_SWITCH <= !mode_chg && tick && scan_wrap;
			SCAN_ON <= !mode_chg && MODE == SCANNING && ph_r < {1'b0, win_ms};
		end
	end

	// setup and supervision timers, saturating
	always_ff @(posedge CLK) begin
		if (SYS_RST || !CONN_PENDING) setup_r <= '0;
		else if (tick && setup_r < setup_ms) setup_r <= setup_r + 16'h1;
		if (SYS_RST || !conn || LINK_ACTIVITY) sup_r <= '0;
		else if (tick && sup_r < sup_ms) sup_r <= sup_r + 16'h1;
		SETUP_TIMEOUT <= !SYS_RST && CONN_PENDING && setup_r >= setup_ms;
		LINK_LOST <= !SYS_RST && conn && !LINK_ACTIVITY && sup_r >= sup_ms;
	end

	// interval negotiation as peripheral; a central of our kind always accepts
	always_ff @(posedge CLK) begin
		if (SYS_RST || MODE != PERIPHERAL_LINK) begin
			neg_r <= NEG_OFF;
			tries_r <= '0;
			nt_r <= '0;
		end else begin
			unique case (neg_r)
				NEG_OFF: begin
					neg_r <= INTV_MATCH ? NEG_AGREED : NEG_WAIT;
					nt_r <= first_ms;
				end
				NEG_WAIT: begin
					if (tick && nt_r == 16'h1) neg_r <= NEG_ASK;
					else if (tick) nt_r <= nt_r - 16'h1;
				end
				NEG_ASK: begin
					if (PEER_ACCEPT) neg_r <= NEG_AGREED;
					else if (PEER_REJECT && tries_r == `NEG_RETRIES) neg_r <= NEG_FAILED;
					else if (PEER_REJECT) begin
						tries_r <= tries_r + 2'h1;
						nt_r <= retry_ms;
						neg_r <= NEG_WAIT;
					end
				end
				NEG_AGREED, NEG_FAILED: neg_r <= neg_r;
			endcase
		end
	end

	// connection outputs; interval bounds always from our link profile
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			INTV_REQ <= 1'b0;
			LINK_SHUTDOWN <= 1'b0;
			UPDATE_ACCEPT <= 1'b0;
			OWN_INTV <= 1'b0;
			INTV_MIN <= '0;
			INTV_MAX <= '0;
		end else begin
			INTV_REQ <= MODE == PERIPHERAL_LINK && neg_r == NEG_WAIT && tick && nt_r == 16'h1;
			LINK_SHUTDOWN <= MODE == PERIPHERAL_LINK && neg_r == NEG_FAILED;
			UPDATE_ACCEPT <= conn && PEER_UPDATE_REQ;
			OWN_INTV <= MODE == CENTRAL_LINK || (MODE == PERIPHERAL_LINK && neg_r == NEG_AGREED);
			INTV_MIN <= MIN_TAB[16*link_prof_r[2:0] +: 16];
			INTV_MAX <= MAX_TAB[16*link_prof_r[2:0] +: 16];
		end
	end

	// frame receive: start, command, length, index, value, check
	wire [7:0] rx_d = LINK.h_data;
	wire at_cs = rx_pos_r >= `HDR_BYTES && rx_pos_r == rx_len_r + `HDR_BYTES;
	wire frame_done = LINK.h_valid && rx_pos_r != '0 && at_cs;
	wire cs_ok = rx_d == rx_xor_r;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rx_pos_r <= '0;
			rx_cmd_r <= '0;
			rx_len_r <= '0;
			rx_idx_r <= '0;
			rx_val_r <= '0;
			rx_xor_r <= '0;
		end else if (LINK.h_valid) begin
			if (rx_pos_r == '0) begin
				if (rx_d == `START_BYTE) rx_pos_r <= 17'h1; // bytes before a start are dropped
				rx_xor_r <= rx_d;
			end else begin
				rx_xor_r <= rx_xor_r ^ rx_d;
				rx_pos_r <= at_cs ? '0 : rx_pos_r + 17'h1;
				if (rx_pos_r == 17'h1) rx_cmd_r <= rx_d;
				if (rx_pos_r == 17'h2) rx_len_r <= {9'h0, rx_d};
				if (rx_pos_r == 17'h3) rx_len_r[16:8] <= {1'b0, rx_d};
				if (rx_pos_r == 17'h4 && !at_cs) rx_idx_r <= rx_d;
				if (rx_pos_r == 17'h5 && !at_cs) rx_val_r <= rx_d;
			end
		end
	end

	// request checks
	wire is_wr = rx_cmd_r == `CMD_WRITE_REQ;
	wire is_rd = rx_cmd_r == `CMD_READ_REQ;
	wire idx_ok = rx_idx_r == `IDX_LINK || rx_idx_r == `IDX_DISC || rx_idx_r == `IDX_RATIO;
	wire val_ok = (rx_idx_r == `IDX_LINK && rx_val_r <= `LINK_MAX)
		|| (rx_idx_r == `IDX_DISC && rx_val_r <= `DISC_MAX)
		|| (rx_idx_r == `IDX_RATIO && rx_val_r >= `RATIO_MIN && rx_val_r <= `RATIO_MAX);
	wire wr_ok = is_wr && rx_len_r == `WRITE_LEN && idx_ok && val_ok;
	wire rd_ok = is_rd && rx_len_r == `READ_LEN && idx_ok;
	wire accept = frame_done && cs_ok && (is_wr || is_rd); // bad check byte: silently dropped
	wire [7:0] cur_val = rx_idx_r == `IDX_LINK ? link_prof_r :
		rx_idx_r == `IDX_DISC ? disc_prof_r : ratio_r;

	// settings store
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			link_prof_r <= `LINK_DEF;
			disc_prof_r <= `DISC_DEF;
			ratio_r <= `RATIO_DEF;
		end else if (accept && wr_ok) begin
			if (rx_idx_r == `IDX_LINK) link_prof_r <= rx_val_r;
			if (rx_idx_r == `IDX_DISC) disc_prof_r <= rx_val_r;
			if (rx_idx_r == `IDX_RATIO) ratio_r <= rx_val_r;
		end
	end

	// answer frame; a read answer carries the value only on success
	wire [7:0] rsp_st = (wr_ok || rd_ok) ? `STATUS_OK : `STATUS_FAIL;
	wire [7:0] rsp_val = rd_ok ? cur_val : 8'h00;
	always_comb begin
		rsp_b[0] = `START_BYTE;
		rsp_b[1] = is_wr ? `CMD_WRITE_CNF : `CMD_READ_CNF;
		rsp_b[2] = rd_ok ? `RSP_LEN_READ : `RSP_LEN_WRITE;
		rsp_b[3] = 8'h00;
		rsp_b[4] = rsp_st;
		rsp_b[6] = rsp_b[0] ^ rsp_b[1] ^ rsp_b[2] ^ rsp_b[3] ^ rsp_b[4] ^ rsp_val;
		rsp_b[5] = rd_ok ? rsp_val : rsp_b[6];
	end

	// answer sender, one byte per cycle
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			tx_n_r <= '0;
			tx_pos_r <= '0;
			LINK.d_valid <= 1'b0;
			LINK.d_data <= '0;
		end else if (accept) begin
			tx_b_r <= rsp_b;
			tx_n_r <= rd_ok ? `WRITE_FRAME_BYTES : `READ_FRAME_BYTES;
			tx_pos_r <= '0;
			LINK.d_valid <= 1'b0;
		end else if (tx_pos_r < tx_n_r) begin
			LINK.d_valid <= 1'b1;
			LINK.d_data <= tx_b_r[tx_pos_r];
			tx_pos_r <= tx_pos_r + 3'h1;
		end else begin
			LINK.d_valid <= 1'b0;
		end
	end
endmodule // timing_sched_device

//--- logic/timing_sched_host.sv
// Purpose: host controller sending setting write and read frames
// Assumes: one request outstanding at a time; device always answers valid frames
// Notes: software polls busy or waits for the done interrupt
`include "timing_sched_consts.svh"
module timing_sched_host
	import timing_sched_pkg::*;
(
	input wire logic CLK, // system clock
	input wire logic SYS_RST, // synchronous reset, high
	setting_link_if.host LINK, // command byte link
	input wire logic [3:0] ADDR, // register byte address
	input wire logic [31:0] WDATA, // write data
	input wire logic WR, // write strobe
	input wire logic RD, // read strobe
	output logic [31:0] RDATA, // read data, cycle after RD
	output logic IRQ // level interrupt
);
	logic [7:0] idx_r, val_r, res_val_r, res_st_r, exp_cmd_r, rx_cmd_r, rx_xor_r;
	logic [1:0] stat_r, mask_r;
	logic busy_r;
	logic [7:0] tx_b_r [7];
	logic [7:0] frm [7];
	logic [2:0] tx_n_r, tx_pos_r;
	logic [16:0] rx_pos_r, rx_len_r;

	// register decode
	wire go = WR && ADDR == `REG_CTRL && WDATA[`CTRL_GO] && !busy_r;
	wire wr_req = WDATA[`CTRL_WRITE];
	wire [7:0] rx_d = LINK.d_data;
	wire at_cs = rx_pos_r >= `HDR_BYTES && rx_pos_r == rx_len_r + `HDR_BYTES;
	wire done = LINK.d_valid && rx_pos_r != '0 && at_cs;
	wire bad = rx_d != rx_xor_r || rx_cmd_r != exp_cmd_r || res_st_r != `STATUS_OK;
	wire [1:0] ev = {done && bad, done};
	assign IRQ = |(stat_r & mask_r);

	// request frame built from the control word
	always_comb begin
		frm[0] = `START_BYTE;
		frm[1] = wr_req ? `CMD_WRITE_REQ : `CMD_READ_REQ;
		frm[2] = wr_req ? 8'(`WRITE_LEN) : 8'(`READ_LEN);
		frm[3] = 8'h00;
		frm[4] = WDATA[15:8];
		frm[6] = frm[0] ^ frm[1] ^ frm[2] ^ frm[3] ^ frm[4] ^ (wr_req ? WDATA[23:16] : 8'h00);
		frm[5] = wr_req ? WDATA[23:16] : frm[6];
	end

	// registers and sender; event set wins over write-one clear
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			stat_r <= '0;
			mask_r <= '0;
			busy_r <= 1'b0;
			idx_r <= '0;
			val_r <= '0;
			exp_cmd_r <= '0;
			tx_n_r <= '0;
			tx_pos_r <= '0;
			RDATA <= '0;
			LINK.h_valid <= 1'b0;
			LINK.h_data <= '0;
		end else begin
			stat_r <= (stat_r & ~((WR && ADDR == `REG_STATUS) ? WDATA[1:0] : 2'h0)) | ev;
			if (WR && ADDR == `REG_MASK) mask_r <= WDATA[1:0];
			RDATA <= !RD ? 32'h0 : ADDR == `REG_CTRL ? {8'h0, val_r, idx_r, 8'h0} :
				ADDR == `REG_STATUS ? {30'h0, stat_r} : ADDR == `REG_MASK ? {30'h0, mask_r} :
				ADDR == `REG_RESULT ? {15'h0, busy_r, res_st_r, res_val_r} : 32'h0;
			if (go) begin
				busy_r <= 1'b1;
				idx_r <= WDATA[15:8];
				val_r <= WDATA[23:16];
				exp_cmd_r <= wr_req ? `CMD_WRITE_CNF : `CMD_READ_CNF;
				tx_b_r <= frm;
				tx_n_r <= wr_req ? `WRITE_FRAME_BYTES : `READ_FRAME_BYTES;
				tx_pos_r <= '0;
			end else if (done) begin
				busy_r <= 1'b0;
			end
			LINK.h_valid <= !go && tx_pos_r < tx_n_r;
			if (!go && tx_pos_r < tx_n_r) begin
				LINK.h_data <= tx_b_r[tx_pos_r];
				tx_pos_r <= tx_pos_r + 3'h1;
			end
		end
	end

	// answer receive and check
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rx_pos_r <= '0;
			rx_len_r <= '0;
			rx_cmd_r <= '0;
			rx_xor_r <= '0;
			res_st_r <= '0;
			res_val_r <= '0;
		end else if (LINK.d_valid) begin
			if (rx_pos_r == '0) begin
				if (rx_d == `START_BYTE) rx_pos_r <= 17'h1;
				rx_xor_r <= rx_d;
			end else begin
				rx_xor_r <= rx_xor_r ^ rx_d;
				rx_pos_r <= at_cs ? '0 : rx_pos_r + 17'h1;
				if (rx_pos_r == 17'h1) rx_cmd_r <= rx_d;
				if (rx_pos_r == 17'h2) rx_len_r <= {9'h0, rx_d};
				if (rx_pos_r == 17'h3) rx_len_r[16:8] <= {1'b0, rx_d};
				if (rx_pos_r == 17'h4 && !at_cs) res_st_r <= rx_d;
				if (rx_pos_r == 17'h5 && !at_cs) res_val_r <= rx_d;
			end
		end
	end
endmodule // timing_sched_host

//--- test/link_properties.sv
// Purpose: watches the setting byte link between host and device
// Assumes: host sends only well formed frames, one at a time
// Notes: read answers are judged for the success shape only
module link_properties (
	input wire logic CLK, // system clock
	input wire logic SYS_RST, // synchronous reset, high
	input wire logic h_valid, // host byte valid
	input wire logic [7:0] h_data, // host byte
	input wire logic d_valid, // device byte valid
	input wire logic [7:0] d_data // device byte
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	// frame shapes on each direction
	sequence host_wr;
		$rose(h_valid) ##1 h_valid && h_data == 8'h11 ##5 h_valid;
	endsequence
	sequence host_rd;
		$rose(h_valid) ##1 h_valid && h_data == 8'h10 ##4 h_valid;
	endsequence
	sequence wr_cnf;
		$rose(d_valid) && d_data == 8'h02 ##1 d_data == 8'h51;
	endsequence
	sequence rd_ok;
		$rose(d_valid) && d_data == 8'h02 ##1 d_data == 8'h50 ##1 d_data == 8'h02
			##1 d_data == 8'h00 ##1 d_data == 8'h00;
	endsequence
	chk_host_start_byte: assert property (
		$rose(h_valid) |-> h_data == 8'h02) else $error("host frame start wrong");
	chk_dev_start_byte: assert property (
		$rose(d_valid) |-> d_data == 8'h02) else $error("answer start wrong");
	chk_dev_command: assert property (
		$rose(d_valid) |=> d_valid && (d_data == 8'h50 || d_data == 8'h51))
		else $error("answer command wrong");
	chk_write_answer_delay: assert property (
		host_wr |-> ##2 $rose(d_valid)) else $error("write answer late");
	chk_read_answer_delay: assert property (
		host_rd |-> ##2 $rose(d_valid)) else $error("read answer late");
	chk_write_cnf_len: assert property (
		wr_cnf |=> d_data == 8'h01 ##1 d_data == 8'h00) else $error("confirm length wrong");
	chk_write_cnf_span: assert property (
		wr_cnf |-> d_valid [*5] ##1 !d_valid) else $error("confirm byte count wrong");
	chk_write_cnf_sum: assert property (
		wr_cnf ##3 1'b1 |=> d_data == (8'h52 ^ $past(d_data)))
		else $error("confirm check byte wrong");
	chk_read_cnf_sum: assert property (
		rd_ok |=> d_valid ##1 (d_valid && d_data == (8'h50 ^ $past(d_data))) ##1 !d_valid)
		else $error("read answer check byte wrong");
endmodule // link_properties

//--- test/tb.sv
// Purpose: drives host registers and device radio inputs, judges outputs
// Assumes: millisecond shortened to MS cycles
// Notes: timeout figures allow slack of two ticks for prescaler phase; period and window counts are exact
module tb import timing_sched_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int MS = 2;
	logic CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic [3:0] ADDR = 4'h0;
	logic [31:0] WDATA = 32'h0;
	logic WR = 1'b0, RD = 1'b0, IRQ;
	logic [31:0] RDATA;
	mode_type MODE = IDLE_ADV;
	logic CONN_PENDING = 1'b0, LINK_ACTIVITY = 1'b0, INTV_MATCH = 1'b1;
	logic PEER_ACCEPT = 1'b0, PEER_REJECT = 1'b0, PEER_UPDATE_REQ = 1'b0;
	logic ADV_TX, SCAN_ON, CHAN_SWITCH, SETUP_TIMEOUT, LINK_LOST, INTV_REQ;
	logic LINK_SHUTDOWN, UPDATE_ACCEPT, OWN_INTV;
	logic [15:0] INTV_MIN, INTV_MAX;
	logic [15:0] min_t [7] = '{16'h0008, 16'h0014, 16'h0032, 16'h00c8, 16'h02ee, 16'h07d0, 16'h0008};
	logic [15:0] max_t [7] = '{16'h001e, 16'h004b, 16'h00fa, 16'h03e8, 16'h08ca, 16'h0fa0, 16'h0008};
	int fail_count = 0, checks = 0, cyc = 0, n = 0;
	logic [31:0] r;
	setting_link_if link ();
	timing_sched_host timing_sched_host_inst (.CLK(CLK), .SYS_RST(SYS_RST), .LINK(link),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ));
	timing_sched_device #(.MS_CYCLES(MS)) timing_sched_device_inst (.CLK(CLK),
		.SYS_RST(SYS_RST), .LINK(link), .MODE(MODE), .CONN_PENDING(CONN_PENDING),
		.LINK_ACTIVITY(LINK_ACTIVITY), .INTV_MATCH(INTV_MATCH), .PEER_ACCEPT(PEER_ACCEPT),
		.PEER_REJECT(PEER_REJECT), .PEER_UPDATE_REQ(PEER_UPDATE_REQ), .ADV_TX(ADV_TX),
		.SCAN_ON(SCAN_ON), .CHAN_SWITCH(CHAN_SWITCH), .SETUP_TIMEOUT(SETUP_TIMEOUT),
		.LINK_LOST(LINK_LOST), .INTV_REQ(INTV_REQ), .LINK_SHUTDOWN(LINK_SHUTDOWN),
		.UPDATE_ACCEPT(UPDATE_ACCEPT), .OWN_INTV(OWN_INTV), .INTV_MIN(INTV_MIN),
		.INTV_MAX(INTV_MAX));
	link_properties link_properties_inst (.CLK(CLK), .SYS_RST(SYS_RST),
		.h_valid(link.h_valid), .h_data(link.h_data), .d_valid(link.d_valid),
		.d_data(link.d_data));
	always #2 CLK = ~CLK;
	// comparison, verdict and hang guard
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			fail_count++;
			stop_test();
		end
	end
	// register bus: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask
	// one setting access; waits on the done interrupt, judges and clears it
	task automatic xfer(input logic w, input logic [7:0] idx, val, es, ev);
		int k;
		logic [31:0] res, st;
		k = 0;
		wr(4'h0, {8'h00, val, idx, 6'h00, w, 1'b1});
		while (IRQ !== 1'b1 && k < 200) begin
			@(posedge CLK);
			#1 k++;
		end
		rd(4'hc, res);
		rd(4'h4, st);
		check(res[15:8], es);
		check(st[1:0], {es != 8'h00, 1'b1});
		if (!w)
			check(res[7:0], ev);
		wr(4'h4, 32'h3);
		#1 check(IRQ, 1'b0);
	endtask
	// cycles until a signal is next seen high
	task automatic gap(ref logic s, output int m);
		m = 0;
		do begin
			@(posedge CLK);
			#1 m++;
		end while (s !== 1'b1 && m < 70000);
	endtask
	task automatic near(input int m, input int e);
		check(m >= e - 2 * MS && m <= e + 2 * MS, 1'b1);
	endtask
	// one-cycle peer pulse: 0 update request, 1 reject, 2 accept
	task automatic pulse(input int k);
		@(posedge CLK);
		PEER_UPDATE_REQ <= k == 0;
		PEER_REJECT <= k == 1;
		PEER_ACCEPT <= k == 2;
		@(posedge CLK);
		{PEER_UPDATE_REQ, PEER_REJECT, PEER_ACCEPT} <= 3'h0;
	endtask
	task automatic t_settings();
		wr(4'h8, 32'h1);
		xfer(1'b0, 8'h08, 8'h00, 8'h00, 8'h01);
		xfer(1'b0, 8'h09, 8'h00, 8'h00, 8'h01);
		xfer(1'b0, 8'h0a, 8'h00, 8'h00, 8'h02);
		check(INTV_MIN, 16'h0014);
		xfer(1'b1, 8'h0a, 8'h03, 8'h00, 8'h00);
		xfer(1'b1, 8'h0a, 8'h0b, 8'h01, 8'h00);
		xfer(1'b1, 8'h0a, 8'h00, 8'h01, 8'h00);
		xfer(1'b1, 8'h09, 8'h06, 8'h01, 8'h00);
		xfer(1'b1, 8'h08, 8'h07, 8'h01, 8'h00);
		xfer(1'b0, 8'h0a, 8'h00, 8'h00, 8'h03);
		for (int p = 0; p < 7; p++) begin
			xfer(1'b1, 8'h08, p[7:0], 8'h00, 8'h00);
			check(INTV_MIN, min_t[p]);
			check(INTV_MAX, max_t[p]);
		end
		// masked done stays quiet until the mask opens
		wr(4'h8, 32'h0);
		wr(4'h0, 32'h00000a01);
		repeat (40) @(posedge CLK);
		#1 check(IRQ, 1'b0);
		wr(4'h8, 32'h1);
		#1 check(IRQ, 1'b1);
		wr(4'h4, 32'h1);
		wr(4'he, 32'hffffffff);
		rd(4'h2, r);
		check(r, 32'h0);
		rd(4'h8, r);
		check(r[1:0], 2'h1);
	endtask
	task automatic t_timing();
		int k;
		k = 0;
		xfer(1'b1, 8'h09, 8'h00, 8'h00, 8'h00);
		gap(ADV_TX, n);
		gap(ADV_TX, n);
		check(n, 20 * MS);
		@(posedge CLK) MODE <= SCANNING;
		gap(CHAN_SWITCH, n);
		gap(CHAN_SWITCH, n);
		check(n, 75 * MS);
		repeat (75 * MS) begin
			@(posedge CLK);
			#1 if (SCAN_ON === 1'b1) k++;
		end
		check(k, 25 * MS);
		@(posedge CLK) CONN_PENDING <= 1'b1;
		gap(SETUP_TIMEOUT, n);
		near(n, 1000 * MS);
		@(posedge CLK) CONN_PENDING <= 1'b0;
	endtask
	task automatic t_links();
		@(posedge CLK) MODE <= CENTRAL_LINK;
		LINK_ACTIVITY <= 1'b1;
		repeat (3) @(posedge CLK);
		#1 check(OWN_INTV, 1'b1);
		pulse(0);
		#1 check(UPDATE_ACCEPT, 1'b1);
		@(posedge CLK) MODE <= PERIPHERAL_LINK;
		INTV_MATCH <= 1'b0;
		repeat (3) @(posedge CLK);
		#1 check(OWN_INTV, 1'b0);
		gap(INTV_REQ, n);
		near(n, 5000 * MS);
		pulse(2);
		repeat (2) @(posedge CLK);
		#1 check(OWN_INTV, 1'b1);
		pulse(0);
		#1 check(UPDATE_ACCEPT, 1'b1);
		// rejoin still mismatched on a silent link; every ask is refused
		@(posedge CLK) MODE <= CENTRAL_LINK;
		@(posedge CLK) MODE <= PERIPHERAL_LINK;
		LINK_ACTIVITY <= 1'b0;
		gap(LINK_LOST, n);
		near(n, 4000 * MS);
		gap(INTV_REQ, n);
		near(n, 1000 * MS);
		for (int i = 0; i < 3; i++) begin
			pulse(1);
			gap(INTV_REQ, n);
			near(n, 10000 * MS);
			check(LINK_SHUTDOWN, 1'b0);
		end
		pulse(1);
		repeat (2) @(posedge CLK);
		#1 check(LINK_SHUTDOWN, 1'b1);
	endtask
	initial begin
		repeat (12) @(posedge CLK);
		SYS_RST <= 1'b0;
		t_settings();
		t_timing();
		t_links();
		stop_test();
	end
endmodule // tb
